/* core/reset_cause_capture.sv */
// Reset cause capture with status register and debug force reset.
// Assumes sources are synchronous to mclk; arst_n is the power-on reset.
//
// What this block does
// RL1: Seven cause flags, bits 7..1, bit 0 zero
// RL2: Debug forced reset clears every cause flag
// RL3: Status write kicks watchdog, keeps flags
// RL4: Power-on sets bits 7 and 1 only
// RL5: Low-voltage reset keeps bit 7, sets bit 1
// RL6: Other resets copy active sources to flags
// RL7: Pin flag set by low reset pin
// RL8: Watchdog reset blocked when option is zero
// RL9: Illegal opcode, or stop or background entry while its option is disabled, set flag
// RL10: Gap after RAM is illegal address
// RL11: Gap before flash is illegal address
// RL12: Register area holes are not illegal
// RL13: Clock generator request sets bit 2
// RL14: Low-voltage reset needs both enables and trip
// RL15: Force register writable only by debug commands
// RL16: Force register reads return zero
// RL17: Writing one to force bit resets device
// RL18: Flags captured at reset end, then held
`include "reset_cause_defines.svh"
`default_nettype none
module reset_cause_capture #(
	parameter logic [15:0] STATUS_ADDR = `RC_STATUS_ADDR_DEF,
	parameter logic [15:0] FORCE_ADDR  = `RC_FORCE_ADDR_DEF
) (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	input  wire logic        bus_valid,
	input  wire logic        bus_write,
	input  wire logic        bus_from_debug,
	input  wire logic [15:0] bus_addr,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        bus_in_register_area,
	output logic      [7:0]  bus_rdata,
	input  wire logic        reset_pin_n,
	input  wire logic        watchdog_timeout,
	input  wire logic        watchdog_enable_option,
	input  wire logic        opcode_illegal,
	input  wire logic        opcode_is_stop,
	input  wire logic        opcode_is_background,
	input  wire logic        stop_enable_option,
	input  wire logic        background_mode_enable,
	input  wire logic        clock_generator_request,
	input  wire logic        low_voltage_trip,
	input  wire logic        low_voltage_reset_enable,
	input  wire logic        low_voltage_stop_enable,
	output logic             watchdog_restart,
	output logic             system_reset
);

	function automatic logic in_illegal_gap(input logic [15:0] a);
		in_illegal_gap = ((a >= `RC_ILL_GAP0_LO) && (a <= `RC_ILL_GAP0_HI)) || // [RL10]
		                 ((a >= `RC_ILL_GAP1_LO) && (a <= `RC_ILL_GAP1_HI));    // [RL11]
	endfunction

	// Exact register decode, shared by the read, kick and force paths
	function automatic logic addr_match(input logic [15:0] a, input logic [15:0] target);
		addr_match = (a == target);
	endfunction

	reset_cause_pkg::cause_s flags_ff;
	reset_cause_pkg::cause_s nxt_flags;
	logic                    capture_now;
	logic                    bus_wr;
	logic                    bus_rd;
	logic                    status_hit;
	logic                    force_hit;
	reset_cause_pkg::cause_s pend_ff;
	reset_cause_pkg::cause_s src;
	reset_cause_pkg::seq_e   state_ff;
	logic                    por_seen_ff;
	logic                    lv_only_ff;
	logic                    forced_ff;
	logic                    illegal_addr;
	logic                    illegal_op;
	logic                    lv_reset;
	logic                    wd_reset;
	logic                    force_wr;
	logic                    any_src;
	logic [7:0]              status_byte;

	assign bus_wr     = bus_valid && bus_write;
	assign bus_rd     = bus_valid && !bus_write;
	assign status_hit = addr_match(bus_addr, STATUS_ADDR);
	assign force_hit  = addr_match(bus_addr, FORCE_ADDR);

	// Holes inside register areas never count [RL12]
	assign illegal_addr = bus_valid && !bus_in_register_area && in_illegal_gap(bus_addr);
	assign illegal_op   = opcode_illegal ||
	                      (opcode_is_stop && !stop_enable_option) ||
	                      (opcode_is_background && !background_mode_enable); // [RL9]
	assign lv_reset     = low_voltage_trip && low_voltage_reset_enable &&
	                      low_voltage_stop_enable; // [RL14]
	assign wd_reset     = watchdog_timeout && watchdog_enable_option; // [RL8]
	// User program writes are dropped here [RL15]
	assign force_wr     = bus_wr && bus_from_debug && force_hit &&
	                      bus_wdata[`RC_BIT_FORCE_RESET]; // [RL17]

	always_comb begin
		src             = '0;
		src.pin         = !reset_pin_n; // [RL7]
		src.watchdog    = wd_reset;
		src.ill_opcode  = illegal_op;
		src.ill_address = illegal_addr;
		src.clock_gen   = clock_generator_request; // [RL13]
	end
	assign any_src = (|src) || lv_reset || force_wr;

	// Reset request state: system_reset held from request until all sources clear
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= reset_cause_pkg::IN_RESET;
		end else if (clk_en) begin
			unique case (state_ff)
				reset_cause_pkg::RUNNING: begin
					if (any_src) begin
						state_ff <= reset_cause_pkg::IN_RESET;
					end
				end
				reset_cause_pkg::IN_RESET: begin
					if (!any_src) begin
						state_ff <= reset_cause_pkg::RUNNING;
					end
				end
				default: state_ff <= reset_cause_pkg::IN_RESET;
			endcase
		end
	end

	// Accumulate sources while reset is held
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pend_ff     <= '0;
			por_seen_ff <= 1'b1;
			lv_only_ff  <= 1'b0;
			forced_ff   <= 1'b0;
		end else if (clk_en) begin
			if (state_ff == reset_cause_pkg::RUNNING) begin
				pend_ff    <= src; // [RL6]
				lv_only_ff <= lv_reset;
				forced_ff  <= force_wr;
				por_seen_ff <= 1'b0;
			end else begin
				pend_ff    <= pend_ff | src;
				lv_only_ff <= lv_only_ff | lv_reset;
				forced_ff  <= forced_ff | force_wr;
			end
		end
	end

	assign capture_now = (state_ff == reset_cause_pkg::IN_RESET) && !any_src;

	// Latched at reset end so later source changes are invisible [RL18]
	always_comb begin
		nxt_flags = flags_ff;
		if (capture_now) begin
			if (por_seen_ff) begin
				nxt_flags             = '0;
				nxt_flags.power_on    = 1'b1; // [RL4]
				nxt_flags.low_voltage = 1'b1; // [RL4]
			end else if (forced_ff) begin
				nxt_flags = '0; // [RL2]
			end else if (lv_only_ff) begin
				nxt_flags             = '0;
				nxt_flags.power_on    = flags_ff.power_on; // [RL5]
				nxt_flags.low_voltage = 1'b1;
			end else begin
				nxt_flags = pend_ff; // [RL6]
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			flags_ff <= '0;
		end else if (clk_en) begin
			flags_ff <= nxt_flags;
		end
	end

	// Write to status address restarts the watchdog, flags untouched [RL3]
	assign watchdog_restart = bus_wr && status_hit;
	assign system_reset     = (state_ff == reset_cause_pkg::IN_RESET);

	assign status_byte = {flags_ff, 1'b0}; // [RL1]

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bus_rdata <= `RC_ZERO8;
		end else if (clk_en) begin
			if (bus_rd && status_hit) begin
				bus_rdata <= status_byte;
			end else begin
				bus_rdata <= `RC_ZERO8; // Force register reads zero [RL16]
			end
		end
	end

endmodule
`default_nettype wire

/* include/reset_cause_defines.svh */
// Constants for the reset cause capture block.
// Assumes an 8-bit peripheral register port on the bus clock.
`ifndef RESET_CAUSE_DEFINES_SVH
`define RESET_CAUSE_DEFINES_SVH

`define RC_BIT_POWER_ON        7
`define RC_BIT_PIN             6
`define RC_BIT_WATCHDOG        5
`define RC_BIT_ILL_OPCODE      4
`define RC_BIT_ILL_ADDRESS     3
`define RC_BIT_CLOCK_GEN       2
`define RC_BIT_LOW_VOLTAGE     1
`define RC_BIT_FORCE_RESET     0
`define RC_ZERO8               8'h00
`define RC_ILL_GAP0_LO         16'h0470
`define RC_ILL_GAP0_HI         16'h17FF
`define RC_ILL_GAP1_LO         16'h1860
`define RC_ILL_GAP1_HI         16'hBFFF
`define RC_STATUS_ADDR_DEF     16'h1800
`define RC_FORCE_ADDR_DEF      16'h1801

`endif

/* include/reset_cause_pkg.sv */
// Types shared by the reset cause capture block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package reset_cause_pkg;
	typedef struct packed {
		logic power_on;
		logic pin;
		logic watchdog;
		logic ill_opcode;
		logic ill_address;
		logic clock_gen;
		logic low_voltage;
	} cause_s;

	typedef enum logic [1:0] {
		RUNNING,
		IN_RESET
	} seq_e;
endpackage
`default_nettype wire

/* verif/bus_host_model.sv */
// Bus host: user program and serial background debug host.
// Assumes it alone drives the block's bus inputs.
`default_nettype none
module bus_host_model (
	input  wire logic  mclk,
	output logic       bus_valid,
	output logic       bus_write,
	output logic       bus_from_debug,
	output logic[15:0] bus_addr,
	output logic[7:0]  bus_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {bus_valid, bus_write, bus_from_debug, bus_addr, bus_wdata} = 27'h0;
	// Background commands set dbg; a user program never does
	task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w, dbg);
		@(posedge mclk) #1;
		{bus_valid, bus_write, bus_from_debug, bus_addr, bus_wdata} = {1'b1, w, dbg, a, d};
		@(posedge mclk) #1;
		bus_valid = 1'b0;
		// Released lines must not keep the old value
		bus_addr = ~bus_addr;
		bus_wdata = ~bus_wdata;
	endtask
endmodule
`default_nettype wire

/* verif/reset_cause_capture_assertions.sv */
// Checker for the reset cause capture block.
// Assumes it is bound to the top module.
`default_nettype none
module reset_cause_capture_assertions #(
	parameter logic [15:0] STATUS_ADDR = 16'h1800,
	parameter logic [15:0] FORCE_ADDR  = 16'h1801
) (
	input wire logic mclk, arst_n, clk_en, bus_valid, bus_write, bus_from_debug,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata, bus_rdata,
	input wire logic bus_in_register_area, reset_pin_n, watchdog_timeout, opcode_illegal,
	input wire logic opcode_is_stop, opcode_is_background, clock_generator_request,
	input wire logic low_voltage_trip, watchdog_restart, system_reset
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	wire quiet = reset_pin_n & ~watchdog_timeout & ~opcode_illegal & ~opcode_is_stop
		& ~opcode_is_background & ~clock_generator_request & ~low_voltage_trip;
	wire live = clk_en & ~system_reset;
	wire acc = live & bus_valid & ~bus_in_register_area;
	wire wr_force = live & bus_valid & bus_write & bus_addr == FORCE_ADDR;
	a_bit_zero: assert property (bus_rdata[0] == 1'b0) else $error("bit 0 set");
	a_force_reads_zero: assert property (clk_en & bus_valid & ~bus_write
		& bus_addr == FORCE_ADDR |=> bus_rdata == 8'h00) else $error("force read");
	a_kick_watchdog: assert property (live & bus_valid & bus_write
		& bus_addr == STATUS_ADDR |-> watchdog_restart) else $error("no kick");
	a_pin_resets: assert property (live & ~reset_pin_n |=> system_reset)
		else $error("pin");
	a_gap_low: assert property (acc & bus_addr inside {[16'h0470:16'h17FF]}
		|=> system_reset) else $error("gap low");
	a_gap_high: assert property (acc & bus_addr inside {[16'h1860:16'hBFFF]}
		|=> system_reset) else $error("gap high");
	a_debug_force: assert property (wr_force & bus_from_debug & bus_wdata[0]
		|=> system_reset) else $error("debug force");
	a_user_force_ignored: assert property (wr_force & ~bus_from_debug & quiet
		|=> ~system_reset) else $error("user force");
	c_debug: cover property (wr_force & bus_from_debug);
	c_release: cover property ($fell(system_reset));
	c_kick: cover property (watchdog_restart);
endmodule
bind reset_cause_capture reset_cause_capture_assertions #(.STATUS_ADDR(STATUS_ADDR),
	.FORCE_ADDR(FORCE_ADDR)) checker_inst (.mclk, .arst_n, .clk_en, .bus_valid, .bus_write,
	.bus_from_debug, .bus_addr, .bus_wdata, .bus_rdata, .bus_in_register_area,
	.reset_pin_n, .watchdog_timeout, .opcode_illegal, .opcode_is_stop,
	.opcode_is_background, .clock_generator_request, .low_voltage_trip,
	.watchdog_restart, .system_reset);
`default_nettype wire

/* verif/reset_cause_capture_bench.sv */
// Bench for the reset cause capture block.
// Assumes the bus host model owns the bus inputs.
`default_nettype none
module reset_cause_capture_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, arst_n = 1'b0, area = 1'b0, wd_en = 1'b1;
	logic ce = 1'b1, stop_en = 1'b0, bg_en = 1'b0, lv_en = 1'b1;
	logic bus_valid, bus_write, bus_from_debug, watchdog_restart, system_reset;
	logic [15:0] bus_addr;
	logic [7:0] bus_wdata, bus_rdata;
	logic [6:0] src = 7'h00;
	logic [30:0] rows [13];
	int fail_count = 0, n_compared = 0;
	reset_cause_capture reset_cause_capture_inst (.mclk, .arst_n, .clk_en(ce), .bus_valid,
		.bus_write, .bus_from_debug, .bus_addr, .bus_wdata, .bus_in_register_area(area),
		.bus_rdata, .reset_pin_n(~src[6]), .watchdog_timeout(src[5]),
		.watchdog_enable_option(wd_en), .opcode_illegal(src[4]), .opcode_is_stop(src[3]),
		.opcode_is_background(src[2]), .stop_enable_option(stop_en),
		.background_mode_enable(bg_en), .clock_generator_request(src[1]),
		.low_voltage_trip(src[0]), .low_voltage_reset_enable(lv_en),
		.low_voltage_stop_enable(1'b1), .watchdog_restart, .system_reset);
	bus_host_model bus_host_model_inst (.mclk, .bus_valid, .bus_write, .bus_from_debug,
		.bus_addr, .bus_wdata);
	always #10 mclk = ~mclk;
	task automatic chk(input string name, input logic [7:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		bus_host_model_inst.access(a, 8'h00, 1'b0, 1'b0);
		chk("read data", exp, bus_rdata);
	endtask
	task automatic settle();
		for (int k = 0; k < 50 && system_reset !== 1'b0; k++) @(posedge mclk) #1;
		if (system_reset !== 1'b0) begin
			fail_count++;
			finish_test();
		end
	endtask
	initial begin
		// Sources {pin, wdog, opcode, stop, background_entry_instruction, clkgen, lv}, address, flags
		rows = '{{7'h01, 16'h0, 8'h82}, {7'h40, 16'h0, 8'h40}, {7'h01, 16'h0, 8'h02},
			{7'h20, 16'h0, 8'h20}, {7'h10, 16'h0, 8'h10}, {7'h08, 16'h0, 8'h10},
			{7'h04, 16'h0, 8'h10}, {7'h02, 16'h0, 8'h04}, {7'h00, 16'h0470, 8'h08},
			{7'h00, 16'h17FF, 8'h08}, {7'h00, 16'h1860, 8'h08},
			{7'h00, 16'hBFFF, 8'h08}, {7'h42, 16'h0, 8'h44}};
		repeat (5) @(posedge mclk);
		#1 arst_n = 1'b1;
		settle();
		rd(16'h1800, 8'h82);
		foreach (rows[i]) begin
			src = rows[i][30:24];
			bus_host_model_inst.access(rows[i][23:8], 8'h00, 1'b0, 1'b0);
			src = 7'h00;
			settle();
			rd(16'h1800, rows[i][7:0]);
		end
		fork
			bus_host_model_inst.access(16'h1800, 8'hFF, 1'b1, 1'b0);
			begin
				@(posedge mclk) #2;
				chk("restart", 8'h01, {7'h00, watchdog_restart});
			end
		join
		rd(16'h1800, 8'h44);
		rd(16'h1801, 8'h00);
		bus_host_model_inst.access(16'h1801, 8'h01, 1'b1, 1'b0);
		rd(16'h1800, 8'h44);
		area = 1'b1;
		rd(16'h0500, 8'h00);
		area = 1'b0;
		rd(16'h1800, 8'h44);
		wd_en = 1'b0;
		src = 7'h20;
		rd(16'h1800, 8'h44);
		src = 7'h00;
		bus_host_model_inst.access(16'h1801, 8'h01, 1'b1, 1'b1);
		settle();
		rd(16'h1800, 8'h00);
		stop_en = 1'b1;
		bg_en = 1'b1;
		src = 7'h0C;
		rd(16'h1800, 8'h00);
		src = 7'h00;
		lv_en = 1'b0;
		src = 7'h01;
		rd(16'h1800, 8'h00);
		src = 7'h00;
		ce = 1'b0;
		src = 7'h40;
		repeat (3) @(posedge mclk) #1;
		chk("frozen reset", 8'h00, {7'h00, system_reset});
		src = 7'h00;
		ce = 1'b1;
		rd(16'h1800, 8'h00);
		arst_n = 1'b0;
		@(posedge mclk) #1;
		arst_n = 1'b1;
		settle();
		rd(16'h1800, 8'h82);
		finish_test();
	end
endmodule
`default_nettype wire
